// [common/epi_pkg.sv]
// package for the external pin interrupt block: map, fields, resets
package epi_pkg;

  // ----------------------------------------------------------------
  // bus and register map
  // ----------------------------------------------------------------
  localparam int          EPI_DATA_W   = 32;     // ahb data width
  localparam int          EPI_ADDR_W   = 8;      // decoded address bits
  localparam int          EPI_PC_W     = 16;     // pin-change inputs
  localparam int          EPI_GRP_W    = 8;      // pins per group
  localparam logic [7:0]  EPI_OFS_SENSE  = 8'h00; // ext_sense_control
  localparam logic [7:0]  EPI_OFS_ENABLE = 8'h04; // ext_irq_enable_mask
  localparam logic [7:0]  EPI_OFS_FLAGS  = 8'h08; // ext_irq_flag_register
  localparam logic [7:0]  EPI_OFS_MSK_HI = 8'h0c; // pc_group_hi_pin_mask
  localparam logic [7:0]  EPI_OFS_MSK_LO = 8'h10; // pc_group_lo_pin_mask
  localparam logic [7:0]  EPI_OFS_STATUS = 8'h14; // sampled pin levels

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int EPI_BIT_HI  = 7;  // upper group enable / flag
  localparam int EPI_BIT_LO  = 6;  // lower group enable / flag
  localparam int EPI_BIT_EXT = 0;  // dedicated pin enable / flag
  localparam int EPI_STS_EXT = 16; // status: sampled dedicated pin

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  EPI_RST_SENSE = 2'h0;
  localparam logic [7:0]  EPI_RST_BYTE  = 8'h00;
  localparam logic [31:0] EPI_RD_ZERO   = 32'h0000_0000;

  // ----------------------------------------------------------------
  // ahb codes
  // ----------------------------------------------------------------
  localparam logic [1:0]  EPI_HTRANS_NONSEQ = 2'h2;
  localparam int          EPI_HTRANS_ACT    = 1;   // set for nonseq/seq
  localparam logic        EPI_HRESP_OKAY    = 1'b0;

  // sense modes of the dedicated pin
  typedef enum logic [1:0] {
    EPI_SENSE_LOW  = 2'b00,  // low level requests
    EPI_SENSE_ANY  = 2'b01,  // any logical change
    EPI_SENSE_FALL = 2'b10,  // falling edge
    EPI_SENSE_RISE = 2'b11   // rising edge
  } epi_sense_e;

endpackage : epi_pkg

// [hw/epi_ext_irq.sv]
// external pin and pin-change interrupt detector with ahb-lite registers
//
// Operation
// - pins interrupt even when driven as outputs
// - enabled toggle on inputs 15..8 requests hi
// - enabled toggle on inputs 7..0 requests lo
// - per-group mask registers pick contributing pins
// - pin changes raise wake without clock edge
// - low-level mode requests while pin stays low
// - edges detected only while clock runs
// - low level raises wake without a clock
// - vanished level wake gives no interrupt
// - dedicated request needs global flag and enable
// - pin sampled first; longer pulses always caught
// - sense field 00 low,01 any,10 fall,11 rise
// - enable bit 7 gates upper group request
// - enable bit 6 gates lower group request
// - enable bit 0 gates dedicated pin request
// - flags set by events, cleared by ack/w1c
// - dedicated flag held clear in level mode
// - pin needs mask bit and group enable
//
// The implementer's own choices: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`default_nettype none

module epi_ext_irq (
  input  wire logic                          SYS_CLK,
  input  wire logic                          SRST,
  // ahb-lite slave
  input  wire logic                          HSEL,
  input  wire logic [epi_pkg::EPI_DATA_W-1:0] HADDR,
  input  wire logic [1:0]                    HTRANS,
  input  wire logic                          HWRITE,
  input  wire logic [2:0]                    HSIZE,
  input  wire logic [epi_pkg::EPI_DATA_W-1:0] HWDATA,
  input  wire logic                          HREADY,
  output logic      [epi_pkg::EPI_DATA_W-1:0] HRDATA,
  output logic                               HREADYOUT,
  output logic                               HRESP,
  // pins and cpu side
  input  wire logic                          EXT_IRQ_PIN,
  input  wire logic [epi_pkg::EPI_PC_W-1:0]  PIN_CHANGE_INPUTS,
  input  wire logic                          GLOBAL_IRQ_EN,
  input  wire logic                          ACK_EXT,
  input  wire logic                          ACK_PC_HI,
  input  wire logic                          ACK_PC_LO,
  output logic                               EXT_IRQ_REQ,
  output logic                               PC_GROUP_HI_REQUEST,
  output logic                               PC_GROUP_LO_REQUEST,
  output logic                               WAKE_REQ
);
  import epi_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0]           sense_q;      // sense_sel_hi / sense_sel_lo
  logic [7:0]           enable_q;     // group and pin enables
  logic [7:0]           flags_q;      // sticky request flags
  logic [EPI_GRP_W-1:0] mask_hi_q;    // upper group pin mask
  logic [EPI_GRP_W-1:0] mask_lo_q;    // lower group pin mask
  logic [EPI_PC_W-1:0]  pc_s1_q;      // first sync stage, pins
  logic [EPI_PC_W-1:0]  pc_s2_q;      // second sync stage, pins
  logic [EPI_PC_W-1:0]  pc_prev_q;    // previous sampled pins
  logic                 ext_s1_q;     // first sync stage, ext pin
  logic                 ext_s2_q;     // second sync stage, ext pin
  logic                 ext_prev_q;   // previous sampled ext pin
  logic                 wr_pend_q;    // write data phase pending
  logic [EPI_ADDR_W-1:0] addr_q;      // latched address
  logic [EPI_PC_W-1:0]  pc_change;    // per-pin toggle seen
  logic [EPI_GRP_W-1:0] hi_hits;      // enabled toggles, upper
  logic [EPI_GRP_W-1:0] lo_hits;      // enabled toggles, lower
  logic                 hi_event;     // upper group event
  logic                 lo_event;     // lower group event
  logic                 ext_event;    // dedicated edge event
  logic                 level_mode;   // dedicated pin in low mode
  logic                 addr_take;    // address phase accepted
  logic                 w1c_hit;      // write to the flag register
  logic [7:0]           w1c_bits;     // flags cleared by that write
  epi_sense_e           sense_mode;   // decoded sense field

  assign sense_mode = epi_sense_e'(sense_q);
  assign level_mode = (sense_mode == EPI_SENSE_LOW);

  // ----------------------------------------------------------------
  // ahb-lite slave: address phase capture
  // ----------------------------------------------------------------
  // zero wait states, every answer okay
  assign HREADYOUT = 1'b1;
  assign HRESP     = EPI_HRESP_OKAY;
  assign addr_take = HSEL && HREADY && HTRANS[EPI_HTRANS_ACT];

  // address and direction held for the data phase
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      wr_pend_q <= 1'b0;
      addr_q    <= '0;
    end else if (HREADY) begin
      wr_pend_q <= addr_take && HWRITE;
      // upper address bits ignored: map aliases every 256 bytes
      if (addr_take) begin
        addr_q <= HADDR[EPI_ADDR_W-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // register writes in the data phase
  // ----------------------------------------------------------------
  // only whole-word writes are expected; hsize is not checked
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      sense_q   <= EPI_RST_SENSE;
      enable_q  <= EPI_RST_BYTE;
      mask_hi_q <= EPI_RST_BYTE;
      mask_lo_q <= EPI_RST_BYTE;
    end else if (wr_pend_q) begin
      if (addr_q == EPI_OFS_SENSE) begin
        sense_q <= HWDATA[1:0];
      end else if (addr_q == EPI_OFS_ENABLE) begin
        // only the three implemented enables are kept
        enable_q <= '0;
        enable_q[EPI_BIT_HI]  <= HWDATA[EPI_BIT_HI];
        enable_q[EPI_BIT_LO]  <= HWDATA[EPI_BIT_LO];
        enable_q[EPI_BIT_EXT] <= HWDATA[EPI_BIT_EXT];
      end else if (addr_q == EPI_OFS_MSK_HI) begin
        mask_hi_q <= HWDATA[EPI_GRP_W-1:0];
      end else if (addr_q == EPI_OFS_MSK_LO) begin
        mask_lo_q <= HWDATA[EPI_GRP_W-1:0];
      end
      // unmapped offsets and the read-only status are ignored
    end
  end

  // ----------------------------------------------------------------
  // read mux: data stand in the data phase
  // ----------------------------------------------------------------
  // all sources are flops; a write just before is already visible
  always_comb begin
    HRDATA = EPI_RD_ZERO;
    if (addr_q == EPI_OFS_SENSE) begin
      HRDATA[1:0] = sense_q;
    end else if (addr_q == EPI_OFS_ENABLE) begin
      HRDATA[7:0] = enable_q;
    end else if (addr_q == EPI_OFS_FLAGS) begin
      HRDATA[7:0] = flags_q;
    end else if (addr_q == EPI_OFS_MSK_HI) begin
      HRDATA[EPI_GRP_W-1:0] = mask_hi_q;
    end else if (addr_q == EPI_OFS_MSK_LO) begin
      HRDATA[EPI_GRP_W-1:0] = mask_lo_q;
    end else if (addr_q == EPI_OFS_STATUS) begin
      HRDATA[EPI_PC_W-1:0]  = pc_s2_q;
      HRDATA[EPI_STS_EXT]   = ext_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisers and previous samples
  // ----------------------------------------------------------------
  // pins are watched whatever drives them, so a port driven as an
  // output still triggers: software interrupts come for free
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      pc_s1_q   <= '0;
      pc_s2_q   <= '0;
      pc_prev_q <= '0;
    end else begin
      pc_s1_q   <= PIN_CHANGE_INPUTS;
      pc_s2_q   <= pc_s1_q;
      pc_prev_q <= pc_s2_q;
    end
  end

  // dedicated pin sampled before edge detection
  // reset to high so an idle-high pin looks like no edge; a pin low after reset gives a fall
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      ext_s1_q   <= 1'b1;
      ext_s2_q   <= 1'b1;
      ext_prev_q <= 1'b1;
    end else begin
      ext_s1_q   <= EXT_IRQ_PIN;
      ext_s2_q   <= ext_s1_q;
      ext_prev_q <= ext_s2_q;
    end
  end

  // ----------------------------------------------------------------
  // event detection
  // ----------------------------------------------------------------
  // a pin counts only with its mask bit and its group enable
  assign pc_change = pc_s2_q ^ pc_prev_q;
  assign hi_hits   = pc_change[EPI_PC_W-1:EPI_GRP_W] & mask_hi_q
                     & {EPI_GRP_W{enable_q[EPI_BIT_HI]}};
  assign lo_hits   = pc_change[EPI_GRP_W-1:0] & mask_lo_q
                     & {EPI_GRP_W{enable_q[EPI_BIT_LO]}};
  assign hi_event  = |hi_hits;
  assign lo_event  = |lo_hits;

  // edge detection needs clock edges, so none occur while it stops
  always_comb begin
    ext_event = 1'b0;
    case (sense_mode)
      EPI_SENSE_ANY:  ext_event = ext_s2_q ^ ext_prev_q;
      EPI_SENSE_FALL: ext_event = ext_prev_q & ~ext_s2_q;
      EPI_SENSE_RISE: ext_event = ~ext_prev_q & ext_s2_q;
      default:        ext_event = 1'b0;  // level handled apart
    endcase
  end

  // ----------------------------------------------------------------
  // sticky flags
  // ----------------------------------------------------------------
  assign w1c_hit  = wr_pend_q && (addr_q == EPI_OFS_FLAGS);
  assign w1c_bits = w1c_hit ? HWDATA[7:0] : 8'h00;

  // set wins over ack or write-one-to-clear in the same cycle
  always_ff @(posedge SYS_CLK) begin
    if (SRST) begin
      flags_q <= EPI_RST_BYTE;
    end else begin
      if (hi_event) begin
        flags_q[EPI_BIT_HI] <= 1'b1;
      end else if (ACK_PC_HI || w1c_bits[EPI_BIT_HI]) begin
        flags_q[EPI_BIT_HI] <= 1'b0;
      end
      if (lo_event) begin
        flags_q[EPI_BIT_LO] <= 1'b1;
      end else if (ACK_PC_LO || w1c_bits[EPI_BIT_LO]) begin
        flags_q[EPI_BIT_LO] <= 1'b0;
      end
      if (level_mode) begin
        flags_q[EPI_BIT_EXT] <= 1'b0;
      end else if (ext_event) begin
        flags_q[EPI_BIT_EXT] <= 1'b1;
      end else if (ACK_EXT || w1c_bits[EPI_BIT_EXT]) begin
        flags_q[EPI_BIT_EXT] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // request outputs to the cpu
  // ----------------------------------------------------------------
  // each source has its own line, i.e. its own vector
  assign PC_GROUP_HI_REQUEST = GLOBAL_IRQ_EN && enable_q[EPI_BIT_HI]
                               && flags_q[EPI_BIT_HI];
  assign PC_GROUP_LO_REQUEST = GLOBAL_IRQ_EN && enable_q[EPI_BIT_LO]
                               && flags_q[EPI_BIT_LO];
  // level mode follows the sampled pin: a level gone before the
  // clock is back gives no request, the source must hold it
  assign EXT_IRQ_REQ = GLOBAL_IRQ_EN && enable_q[EPI_BIT_EXT]
                       && (level_mode ? ~ext_s2_q
                                      : flags_q[EPI_BIT_EXT]);

  // ----------------------------------------------------------------
  // clockless wake detection
  // ----------------------------------------------------------------
  // raw pins against held samples: purely combinational, so a stopped
  // clock still wakes; may glitch, the consumer must filter
  assign WAKE_REQ =
    (enable_q[EPI_BIT_EXT] && level_mode && !EXT_IRQ_PIN)
    || (enable_q[EPI_BIT_HI] && |((PIN_CHANGE_INPUTS[EPI_PC_W-1:EPI_GRP_W]
        ^ pc_s2_q[EPI_PC_W-1:EPI_GRP_W]) & mask_hi_q))
    || (enable_q[EPI_BIT_LO] && |((PIN_CHANGE_INPUTS[EPI_GRP_W-1:0]
        ^ pc_s2_q[EPI_GRP_W-1:0]) & mask_lo_q));

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_lvl_flag_clr;
    @(posedge SYS_CLK) disable iff (SRST)
    level_mode |=> !flags_q[EPI_BIT_EXT];
  endproperty
  a_lvl_flag_clr: assert property (p_lvl_flag_clr)
    else $error("ext flag set in level mode");

  property p_lvl_req;
    @(posedge SYS_CLK) disable iff (SRST)
    (level_mode && GLOBAL_IRQ_EN && enable_q[EPI_BIT_EXT] && !ext_s2_q)
      |-> EXT_IRQ_REQ;
  endproperty
  a_lvl_req: assert property (p_lvl_req)
    else $error("low level without request");

  property p_ext_gate;
    @(posedge SYS_CLK) disable iff (SRST)
    EXT_IRQ_REQ |-> (GLOBAL_IRQ_EN && enable_q[EPI_BIT_EXT]);
  endproperty
  a_ext_gate: assert property (p_ext_gate)
    else $error("ext request while gated off");

  property p_hi_set;
    @(posedge SYS_CLK) disable iff (SRST)
    (enable_q[EPI_BIT_HI] && |((pc_s2_q[EPI_PC_W-1:EPI_GRP_W]
      ^ pc_prev_q[EPI_PC_W-1:EPI_GRP_W]) & mask_hi_q))
      |=> flags_q[EPI_BIT_HI];
  endproperty
  a_hi_set: assert property (p_hi_set)
    else $error("upper toggle did not set flag");

  property p_lo_set;
    @(posedge SYS_CLK) disable iff (SRST)
    (enable_q[EPI_BIT_LO] && |((pc_s2_q[EPI_GRP_W-1:0]
      ^ pc_prev_q[EPI_GRP_W-1:0]) & mask_lo_q))
      |=> flags_q[EPI_BIT_LO];
  endproperty
  a_lo_set: assert property (p_lo_set)
    else $error("lower toggle did not set flag");

  property p_hi_cause;
    @(posedge SYS_CLK) disable iff (SRST)
    $rose(flags_q[EPI_BIT_HI]) |-> $past(enable_q[EPI_BIT_HI]);
  endproperty
  a_hi_cause: assert property (p_hi_cause)
    else $error("upper flag set with group disabled");

  property p_rise_set;
    @(posedge SYS_CLK) disable iff (SRST)
    (sense_mode == EPI_SENSE_RISE && $rose(ext_s2_q)
      && $stable(sense_q))
      |=> flags_q[EPI_BIT_EXT];
  endproperty
  a_rise_set: assert property (p_rise_set)
    else $error("rising edge missed");

  property p_pulse_caught;
    @(posedge SYS_CLK) disable iff (SRST)
    (sense_mode == EPI_SENSE_ANY && $changed(EXT_IRQ_PIN)
      && !w1c_hit && !ACK_EXT)
      ##1 (sense_mode == EPI_SENSE_ANY)[*2] |=> flags_q[EPI_BIT_EXT];
  endproperty
  a_pulse_caught: assert property (p_pulse_caught)
    else $error("pin change not flagged in three cycles");

  property p_w1c;
    @(posedge SYS_CLK) disable iff (SRST)
    (w1c_bits[EPI_BIT_LO] && !lo_event) |=> !flags_q[EPI_BIT_LO];
  endproperty
  a_w1c: assert property (p_w1c)
    else $error("write one did not clear lower flag");

  property p_hi_req;
    @(posedge SYS_CLK) disable iff (SRST)
    PC_GROUP_HI_REQUEST == (GLOBAL_IRQ_EN && enable_q[EPI_BIT_HI]
                            && flags_q[EPI_BIT_HI]);
  endproperty
  a_hi_req: assert property (p_hi_req)
    else $error("upper request mismatch");

  c_hi_req: cover property (@(posedge SYS_CLK) disable iff (SRST)
    $rose(PC_GROUP_HI_REQUEST));
  c_lo_req: cover property (@(posedge SYS_CLK) disable iff (SRST)
    $rose(PC_GROUP_LO_REQUEST));
  c_fall_req: cover property (@(posedge SYS_CLK) disable iff (SRST)
    sense_mode == EPI_SENSE_FALL && $rose(EXT_IRQ_REQ));
  c_lvl_req: cover property (@(posedge SYS_CLK) disable iff (SRST)
    level_mode && EXT_IRQ_REQ);

endmodule : epi_ext_irq

`default_nettype wire

// [test/epi_pin_model.sv]
// off-chip pin sources driving the interrupt pins
`timescale 1ns/1ns
`default_nettype none

module epi_pin_model (
  input  wire logic                         SYS_CLK,
  output var  logic                         EXT_IRQ_PIN,
  output var  logic [epi_pkg::EPI_PC_W-1:0] PIN_CHANGE_INPUTS
);
  import epi_pkg::*;

  // ----------------
  // pin levels
  // ----------------
  // dedicated pin idles high, group pins idle low
  initial begin
    EXT_IRQ_PIN       = 1'h1;
    PIN_CHANGE_INPUTS = 16'h0000;
  end

  // same path whether a source or the core's own output drives it
  task automatic set_ext(input logic v);
    EXT_IRQ_PIN <= v;
  endtask : set_ext

  // flips only the chosen lines, others keep level
  task automatic flip_pc(input logic [EPI_PC_W-1:0] m);
    PIN_CHANGE_INPUTS <= PIN_CHANGE_INPUTS ^ m;
  endtask : flip_pc

  // low kept past the instruction in flight, then released
  task automatic hold_low(input int n);
    EXT_IRQ_PIN <= 1'h0;
    repeat (n) @(posedge SYS_CLK);
    EXT_IRQ_PIN <= 1'h1;
  endtask : hold_low
endmodule : epi_pin_model

`default_nettype wire

// [test/epi_ext_irq_bench.sv]
// self-checking bench for the external pin interrupt block
`timescale 1ns/1ns
`default_nettype none

module epi_ext_irq_bench;
  import epi_pkg::*;

  // ----------------
  // compare helper
  // ----------------
  `define EPI_CHK(g, e) begin checks++; if ((g) !== (e)) begin fails++; \
    $display("MISMATCH %0t got %h exp %h", $time, g, e); end end

  logic                  SYS_CLK, SRST, HSEL, HWRITE, GLOBAL_IRQ_EN;
  logic                  ACK_EXT, ACK_PC_HI, ACK_PC_LO, HREADYOUT, HRESP;
  logic                  EXT_IRQ_REQ, PC_GROUP_HI_REQUEST, WAKE_REQ;
  logic                  PC_GROUP_LO_REQUEST, EXT_IRQ_PIN;
  logic [1:0]            HTRANS;
  logic [2:0]            HSIZE;
  logic [EPI_DATA_W-1:0] HADDR, HWDATA, HRDATA, rd;
  logic [EPI_PC_W-1:0]   PIN_CHANGE_INPUTS;
  int                    fails, checks, cyc;

  // register rows: offset, reset value, value after writing ones
  typedef struct {
    logic [7:0] ofs;
    logic [31:0] rst_v;
    logic [31:0] ones_v;
  } epi_reg_s;
  epi_reg_s regs[7] = '{
    '{EPI_OFS_SENSE, 32'h0, 32'h3}, '{EPI_OFS_ENABLE, 32'h0, 32'hc1},
    '{EPI_OFS_FLAGS, 32'h0, 32'h0}, '{EPI_OFS_MSK_HI, 32'h0, 32'hff},
    '{EPI_OFS_MSK_LO, 32'h0, 32'hff},
    '{EPI_OFS_STATUS, 32'h1_0000, 32'h1_0000}, // read-only, pin high
    '{8'h18, 32'h0, 32'h0}};                     // unmapped hole

  // sense rows: mode, start and end level, flag and request
  typedef struct {
    logic [1:0] sense;
    logic p0, p1, flag, req;
  } epi_sns_s;
  epi_sns_s sns[7] = '{
    '{EPI_SENSE_ANY, 1'h1, 1'h0, 1'h1, 1'h1},
    '{EPI_SENSE_ANY, 1'h0, 1'h1, 1'h1, 1'h1},
    '{EPI_SENSE_FALL, 1'h1, 1'h0, 1'h1, 1'h1},
    '{EPI_SENSE_FALL, 1'h0, 1'h1, 1'h0, 1'h0},
    '{EPI_SENSE_RISE, 1'h0, 1'h1, 1'h1, 1'h1},
    '{EPI_SENSE_RISE, 1'h1, 1'h0, 1'h0, 1'h0},
    '{EPI_SENSE_LOW, 1'h1, 1'h0, 1'h0, 1'h1}}; // level: no flag

  epi_ext_irq dut_u (
    .SYS_CLK(SYS_CLK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .EXT_IRQ_PIN(EXT_IRQ_PIN),
    .PIN_CHANGE_INPUTS(PIN_CHANGE_INPUTS), .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN),
    .ACK_EXT(ACK_EXT), .ACK_PC_HI(ACK_PC_HI), .ACK_PC_LO(ACK_PC_LO),
    .EXT_IRQ_REQ(EXT_IRQ_REQ), .PC_GROUP_HI_REQUEST(PC_GROUP_HI_REQUEST),
    .PC_GROUP_LO_REQUEST(PC_GROUP_LO_REQUEST), .WAKE_REQ(WAKE_REQ));

  epi_pin_model pm_u (.SYS_CLK(SYS_CLK), .EXT_IRQ_PIN(EXT_IRQ_PIN),
    .PIN_CHANGE_INPUTS(PIN_CHANGE_INPUTS));

  // ----------------
  // clock, timeout, verdict
  // ----------------
  initial begin
    SYS_CLK = 1'h0;
    forever #10 SYS_CLK = ~SYS_CLK;
  end

  // the run needs some 230 cycles, so 4000 means a hang
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("counts: %0d checks, %0d fails", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // one single ahb-lite transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd);
    HSEL   <= 1'h1;
    HTRANS <= EPI_HTRANS_NONSEQ;
    HADDR  <= {24'h0, a};
    HWRITE <= w;
    HSIZE  <= 3'h2;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'h1);
    // select only qualifies the address phase, so drop it here
    HSEL   <= 1'h0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge SYS_CLK); while (HREADYOUT !== 1'h1);
    rd = HRDATA;
    `EPI_CHK(HRESP, EPI_HRESP_OKAY)
  endtask : bus

  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask : tick

  // ----------------
  // main sequence
  // ----------------
  initial begin
    {SRST, HSEL, HWRITE, GLOBAL_IRQ_EN} = 4'h8;
    {ACK_EXT, ACK_PC_HI, ACK_PC_LO} = 3'h0;
    {HTRANS, HSIZE, HADDR, HWDATA} = '0;
    tick(8);
    SRST <= 1'h0;
    tick(1);
    // reset values, access kinds, unmapped hole
    foreach (regs[i]) begin
      bus(1'h0, regs[i].ofs, 32'h0);
      `EPI_CHK(rd, regs[i].rst_v)
      bus(1'h1, regs[i].ofs, 32'hffff_ffff);
      bus(1'h0, regs[i].ofs, 32'h0);
      `EPI_CHK(rd, regs[i].ones_v)
    end
    $display("test registers done");
    GLOBAL_IRQ_EN <= 1'h1;
    foreach (sns[i]) begin
      pm_u.set_ext(sns[i].p0);
      bus(1'h1, EPI_OFS_SENSE, {30'h0, sns[i].sense});
      tick(4);
      bus(1'h1, EPI_OFS_FLAGS, 32'hc1);
      pm_u.set_ext(sns[i].p1);
      tick(4);
      @(negedge SYS_CLK);
      `EPI_CHK(EXT_IRQ_REQ, sns[i].req)
      @(posedge SYS_CLK);
      bus(1'h0, EPI_OFS_FLAGS, 32'h0);
      `EPI_CHK(rd[EPI_BIT_EXT], sns[i].flag)
    end
    $display("test sense modes done");
    // two-cycle pulse in any-change mode, exact latency, then ack
    bus(1'h1, EPI_OFS_SENSE, 32'h1);
    pm_u.set_ext(1'h1);
    tick(5);
    bus(1'h1, EPI_OFS_FLAGS, 32'hc1);
    pm_u.set_ext(1'h0);
    tick(2);
    pm_u.set_ext(1'h1);
    // the fall lands in the flag on the third edge after the toggle
    @(negedge SYS_CLK);
    `EPI_CHK(EXT_IRQ_REQ, 1'h0)
    @(negedge SYS_CLK);
    `EPI_CHK(EXT_IRQ_REQ, 1'h1)
    tick(3);
    ACK_EXT <= 1'h1;
    tick(1);
    ACK_EXT <= 1'h0;
    @(negedge SYS_CLK);
    `EPI_CHK(EXT_IRQ_REQ, 1'h0)
    $display("test pulse latency done");
    // low level: wake without clock, gating, gone after release
    @(posedge SYS_CLK);
    bus(1'h1, EPI_OFS_SENSE, 32'h0);
    fork pm_u.hold_low(6); join_none
    @(negedge SYS_CLK);
    `EPI_CHK(WAKE_REQ, 1'h1)
    `EPI_CHK(EXT_IRQ_REQ, 1'h0)
    tick(2);
    @(negedge SYS_CLK);
    `EPI_CHK(EXT_IRQ_REQ, 1'h1)
    @(posedge SYS_CLK);
    GLOBAL_IRQ_EN <= 1'h0;
    @(negedge SYS_CLK);
    `EPI_CHK(EXT_IRQ_REQ, 1'h0)
    @(posedge SYS_CLK);
    GLOBAL_IRQ_EN <= 1'h1;
    tick(5);
    @(negedge SYS_CLK);
    `EPI_CHK(EXT_IRQ_REQ, 1'h0)
    @(posedge SYS_CLK);
    bus(1'h0, EPI_OFS_FLAGS, 32'h0);
    `EPI_CHK(rd[EPI_BIT_EXT], 1'h0)
    $display("test low level done");
    // pin-change groups: masked pins, both groups, gating, ack
    bus(1'h1, EPI_OFS_MSK_HI, 32'h80);
    bus(1'h1, EPI_OFS_MSK_LO, 32'h01);
    pm_u.flip_pc(16'h4002);
    tick(5);
    @(negedge SYS_CLK);
    `EPI_CHK({PC_GROUP_HI_REQUEST, PC_GROUP_LO_REQUEST}, 2'h0)
    @(posedge SYS_CLK);
    pm_u.flip_pc(16'h8000);
    @(negedge SYS_CLK);
    `EPI_CHK(WAKE_REQ, 1'h1)
    tick(4);
    @(negedge SYS_CLK);
    `EPI_CHK({PC_GROUP_HI_REQUEST, PC_GROUP_LO_REQUEST}, 2'h2)
    @(posedge SYS_CLK);
    pm_u.flip_pc(16'h0001);
    tick(4);
    @(negedge SYS_CLK);
    `EPI_CHK({PC_GROUP_HI_REQUEST, PC_GROUP_LO_REQUEST}, 2'h3)
    @(posedge SYS_CLK);
    GLOBAL_IRQ_EN <= 1'h0;
    @(negedge SYS_CLK);
    `EPI_CHK({PC_GROUP_HI_REQUEST, PC_GROUP_LO_REQUEST}, 2'h0)
    @(posedge SYS_CLK);
    GLOBAL_IRQ_EN <= 1'h1;
    ACK_PC_HI <= 1'h1;
    @(posedge SYS_CLK);
    ACK_PC_HI <= 1'h0;
    ACK_PC_LO <= 1'h1;
    @(negedge SYS_CLK);
    `EPI_CHK({PC_GROUP_HI_REQUEST, PC_GROUP_LO_REQUEST}, 2'h1)
    @(posedge SYS_CLK);
    ACK_PC_LO <= 1'h0;
    bus(1'h1, EPI_OFS_ENABLE, 32'h01);
    pm_u.flip_pc(16'h0001);
    tick(5);
    bus(1'h0, EPI_OFS_FLAGS, 32'h0);
    `EPI_CHK(rd[EPI_BIT_HI:EPI_BIT_LO], 2'h0)
    $display("test pin change done");
    // mid-run reset with a live level request: all must drop
    pm_u.set_ext(1'h0);
    tick(3);
    @(negedge SYS_CLK);
    `EPI_CHK(EXT_IRQ_REQ, 1'h1)
    @(posedge SYS_CLK);
    SRST <= 1'h1;
    pm_u.set_ext(1'h1);
    tick(3);
    SRST <= 1'h0;
    @(negedge SYS_CLK);
    `EPI_CHK({EXT_IRQ_REQ, WAKE_REQ}, 2'h0)
    @(posedge SYS_CLK);
    bus(1'h0, EPI_OFS_ENABLE, 32'h0);
    `EPI_CHK(rd, 32'h0)
    $display("test reset done");
    stop_test();
  end
endmodule : epi_ext_irq_bench

`default_nettype wire
